// [logic/alx_load_exec.sv]
`timescale 1ns/1ps
`include "alx_cfg.svh"

module alx_load_exec
  import alx_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire alx_instr_t    instr,
  input  wire alx_mem_t      memRd,
  input  wire logic          sign_ext_mode,
  input  wire logic [15:0]   tempReg,
  input  wire logic          statusPtrWe,
  input  wire logic [2:0]    statusPtr,
  input  wire logic          statusBufWe,
  input  wire logic [2:0]    statusBuf,
  output logic               busy,
  output logic               memReq,
  output logic [31:0]        acc,
  output logic [2:0]         aux_pointer,
  output logic [2:0]         aux_pointer_buffer,
  output logic [8:0]         page_pointer,
  output logic               auxWe,
  output logic [2:0]         auxSel,
  output logic [15:0]        auxData,
  output logic               postModSkip,
  output logic               refused
);

  // ==========================================
  // decode
  // ==========================================
  logic [15:0] w;
  logic        isShortAcc;
  logic        isShortAux;
  logic        isMemAux;
  logic        isTregAcc;
  logic        isPageMem;
  logic        isModAux;
  logic        isLongAcc;
  logic        indirect;
  logic        newPtr;

  assign w          = instr.word;
  assign indirect   = w[`ALX_BIT_INDIRECT];
  assign newPtr     = w[`ALX_BIT_NEWPTR];
  assign isShortAcc = w[`ALX_FLD_OP8] == `ALX_OP_LDACC_SHORT;
  assign isShortAux = w[`ALX_FLD_OP5] == `ALX_OP_LDAUX_SHORT5;
  assign isMemAux   = w[`ALX_FLD_OP5] == `ALX_OP_LDAUX_MEM5;
  assign isTregAcc  = w[`ALX_FLD_OP8] == `ALX_OP_LDACC_TREG;
  assign isPageMem  = w[`ALX_FLD_OP8] == `ALX_OP_LDPAGE_MEM;
  // pointer load shares the modify-aux indirect opcode
  assign isModAux   = w[`ALX_FLD_OP8] == `ALX_OP_MODIFY_AUX;
  logic        longHead;
  logic        longTail;
  assign longHead   = w[`ALX_FLD_OP4] == `ALX_OP_LDACC_LONG4;
  assign longTail   = w[`ALX_FLD_IMM8] == `ALX_OP_LDACC_LONGLO;
  assign isLongAcc  = longHead && longTail;

  // ==========================================
  // data paths
  // ==========================================
  alx_state_t  state;
  alx_state_t  next_state;
  logic [15:0] firstWord;
  logic [3:0]  longShift;
  logic [31:0] longVal;
  logic [31:0] tregVal;
  logic [31:0] shortVal;
  logic [3:0]  tregShift;

  logic [31:0] longExt;
  logic [31:0] tregExt;
  // absent shift field encodes as zero, so no special case
  assign longShift = firstWord[`ALX_FLD_SHIFT];
  // mode on: sign-extend so msb follows operand sign; off: zero-fill
  assign longExt   = sign_ext_mode ? {{16{instr.word[15]}}, instr.word} : {16'h0000, instr.word};
  assign longVal   = longExt << longShift;
  assign tregShift = tempReg[`ALX_FLD_TSHIFT];
  assign tregExt   = sign_ext_mode ? {{16{memRd.data[15]}}, memRd.data} : {16'h0000, memRd.data};
  assign tregVal   = tregExt << tregShift;
  // upper bits cleared whatever the sign mode
  assign shortVal  = {24'h00_0000, w[`ALX_FLD_IMM8]};

  logic startOk;
  logic repRefuse;
  assign repRefuse = instr.valid && (state == ALX_IDLE) && isShortAux && instr.inRepeat;
  assign startOk   = instr.valid && (state == ALX_IDLE) && !repRefuse;

  logic needMem;
  assign needMem = isMemAux || isTregAcc || isPageMem;

  always_comb
  begin
    next_state = state;
    case (state)
      ALX_IDLE:
      begin
        if (startOk && isLongAcc)
          next_state = ALX_LONG;
        else if (startOk && needMem)
          next_state = ALX_MEMWT;
      end
      ALX_LONG:
      begin
        if (instr.valid)
          next_state = ALX_IDLE;
      end
      ALX_MEMWT:
      begin
        if (memRd.valid)
          next_state = ALX_IDLE;
      end
      ALX_DONE:
        next_state = ALX_IDLE;
      default:
        next_state = ALX_IDLE;
    endcase
  end

  // ==========================================
  // pointer update
  // ==========================================
  logic ptrLoad;
  logic [2:0] next_ptr;
  logic [2:0] next_buf;
  assign ptrLoad = startOk && isModAux && indirect && newPtr;
  always_comb
  begin
    next_ptr = aux_pointer;
    next_buf = aux_pointer_buffer;
    if (statusBufWe)
      next_buf = statusBuf;
    if (statusPtrWe)
      next_ptr = statusPtr;
    else if (ptrLoad)
    begin
      next_buf = aux_pointer;
      next_ptr = w[`ALX_FLD_PTR];
    end
    // indirect memory operand may name the next pointer
    else if (startOk && indirect && newPtr && needMem)
      next_ptr = w[`ALX_FLD_PTR];
  end

  // ==========================================
  // completion and target decode
  // ==========================================
  logic        memDone;
  logic        longDone;
  logic        fwMemAux;
  logic        fwTregAcc;
  logic        fwPageMem;
  logic        shortAccGo;
  logic        shortAuxGo;
  logic        memAuxGo;
  logic        tregGo;
  logic        pageGo;
  logic        sameAsPtr;
  logic [2:0]  takePtr;
  logic [15:0] auxImmVal;
  logic [15:0] next_firstWord;
  logic [2:0]  next_takePtr;
  logic [31:0] next_acc;
  logic [8:0]  next_page;
  logic        next_auxWe;
  logic [2:0]  next_auxSel;
  logic [15:0] next_auxData;
  logic        next_postModSkip;
  logic        next_refused;
  logic        next_busy;
  logic        next_memReq;

  assign memDone    = (state == ALX_MEMWT) && memRd.valid;
  assign longDone   = (state == ALX_LONG) && instr.valid;
  assign fwMemAux   = firstWord[`ALX_FLD_OP5] == `ALX_OP_LDAUX_MEM5;
  assign fwTregAcc  = firstWord[`ALX_FLD_OP8] == `ALX_OP_LDACC_TREG;
  assign fwPageMem  = firstWord[`ALX_FLD_OP8] == `ALX_OP_LDPAGE_MEM;
  assign shortAccGo = startOk && isShortAcc;
  assign shortAuxGo = startOk && isShortAux;
  assign memAuxGo   = memDone && fwMemAux;
  assign tregGo     = memDone && fwTregAcc;
  assign pageGo     = memDone && fwPageMem;
  assign auxImmVal  = {8'h00, w[`ALX_FLD_IMM8]};
  // pointer as it stood when the load was taken, not after its own update
  assign sameAsPtr  = firstWord[`ALX_FLD_AUX] == takePtr;

  // ==========================================
  // next values
  // ==========================================
  assign next_firstWord   = startOk ? w : firstWord;
  assign next_takePtr     = startOk ? aux_pointer : takePtr;
  // the three accumulator writers sit in disjoint states
  assign next_acc         = shortAccGo ? shortVal
                          : longDone   ? longVal
                          : tregGo     ? tregVal
                          : acc;
  assign next_page        = pageGo ? memRd.data[`ALX_FLD_PAGE] : page_pointer;
  assign next_auxWe       = shortAuxGo || memAuxGo;
  assign next_auxSel      = shortAuxGo ? w[`ALX_FLD_AUX]
                          : memAuxGo   ? firstWord[`ALX_FLD_AUX]
                          : auxSel;
  assign next_auxData     = shortAuxGo ? auxImmVal
                          : memAuxGo   ? memRd.data
                          : auxData;
  // only the indirect form post-modifies, so only it is suppressed
  assign next_postModSkip = memAuxGo && firstWord[`ALX_BIT_INDIRECT] && sameAsPtr;
  assign next_refused     = repRefuse;
  assign next_busy        = next_state != ALX_IDLE;
  assign next_memReq      = startOk && needMem && !isLongAcc;

  // ==========================================
  // registers
  // ==========================================
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      state <= ALX_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      firstWord <= `ALX_WORD_RST;
      takePtr   <= `ALX_PTR_RST;
    end
    else
    begin
      firstWord <= next_firstWord;
      takePtr   <= next_takePtr;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      acc <= `ALX_ACC_RST;
    else
      acc <= next_acc;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      aux_pointer        <= `ALX_PTR_RST;
      aux_pointer_buffer <= `ALX_PTR_RST;
    end
    else
    begin
      aux_pointer        <= next_ptr;
      aux_pointer_buffer <= next_buf;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      page_pointer <= `ALX_PAGE_RST;
    else
      page_pointer <= next_page;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      auxWe       <= 1'b0;
      auxSel      <= `ALX_PTR_RST;
      auxData     <= `ALX_AUX_RST;
      postModSkip <= 1'b0;
    end
    else
    begin
      auxWe       <= next_auxWe;
      auxSel      <= next_auxSel;
      auxData     <= next_auxData;
      postModSkip <= next_postModSkip;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      busy    <= 1'b0;
      memReq  <= 1'b0;
      refused <= 1'b0;
    end
    else
    begin
      busy    <= next_busy;
      memReq  <= next_memReq;
      refused <= next_refused;
    end
  end

endmodule : alx_load_exec

// [logic/alx_cfg.svh]
`ifndef ALX_CFG_SVH
`define ALX_CFG_SVH
// opcode patterns on the high bits of the first instruction word; ALX_OP_LDACC_LONGLO matches its low byte
`define ALX_OP_LDACC_SHORT  8'hCA
`define ALX_OP_LDAUX_SHORT5 5'h18
`define ALX_OP_LDAUX_MEM5   5'h06
`define ALX_OP_LDACC_TREG   8'h42
`define ALX_OP_LDPAGE_MEM   8'h52
`define ALX_OP_MODIFY_AUX   8'h55
`define ALX_OP_LDACC_LONG4  4'hD
`define ALX_OP_LDACC_LONGLO 8'h01
// field positions
`define ALX_BIT_INDIRECT    7
`define ALX_BIT_NEWPTR      3
`define ALX_FLD_OP8         15:8
`define ALX_FLD_OP5         15:11
`define ALX_FLD_OP4         15:12
`define ALX_FLD_AUX         10:8
`define ALX_FLD_SHIFT       11:8
`define ALX_FLD_IMM8        7:0
`define ALX_FLD_PTR         2:0
`define ALX_FLD_TSHIFT      3:0
`define ALX_FLD_PAGE        8:0
// reset values
`define ALX_ACC_RST         32'h0000_0000
`define ALX_PTR_RST         3'h0
`define ALX_PAGE_RST        9'h000
`define ALX_AUX_RST         16'h0000
`define ALX_WORD_RST        16'h0000
`endif

// [logic/alx_pkg.sv]
package alx_pkg;
  typedef enum logic [3:0] {
    ALX_IDLE  = 4'b0001,
    ALX_LONG  = 4'b0010,
    ALX_MEMWT = 4'b0100,
    ALX_DONE  = 4'b1000
  } alx_state_t;

  // one instruction handed to the executor
  typedef struct packed {
    logic        valid;
    logic [15:0] word;
    logic        inRepeat;
  } alx_instr_t;

  // one memory answer
  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } alx_mem_t;
endpackage : alx_pkg

// [test/alx_load_exec_properties.sv]
`timescale 1ns/1ps
module alx_load_exec_props
  import alx_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire alx_instr_t instr,
  input wire alx_mem_t   memRd,
  input wire logic       statusPtrWe,
  input wire logic [2:0] statusPtr,
  input wire logic       busy,
  input wire logic       memReq,
  input wire logic [31:0] acc,
  input wire logic [2:0] aux_pointer,
  input wire logic [2:0] aux_pointer_buffer,
  input wire logic       auxWe,
  input wire logic [2:0] auxSel,
  input wire logic [15:0] auxData,
  input wire logic       postModSkip,
  input wire logic       refused
);
  // ==========
  // helpers
  wire logic take = instr.valid && !busy;
  wire logic takeAux = take && instr.word[15:11] == 5'h18;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_shacc; take && instr.word[15:8] == 8'hCA |=> acc == {24'h00_0000, $past(instr.word[7:0])}; endproperty
  a_shacc: assert property (p_shacc) else $error("short acc load wrong");
  property p_ptr; take && instr.word[15:3] == 13'h0AB1 && !statusPtrWe
    |=> aux_pointer == $past(instr.word[2:0]) && aux_pointer_buffer == $past(aux_pointer); endproperty
  a_ptr: assert property (p_ptr) else $error("pointer load wrong");
  property p_sts; statusPtrWe |=> aux_pointer == $past(statusPtr); endproperty
  a_sts: assert property (p_sts) else $error("status pointer write lost");
  property p_aux; takeAux && !instr.inRepeat
    |=> auxWe && auxSel == $past(instr.word[10:8]) && auxData == {8'h00, $past(instr.word[7:0])}; endproperty
  a_aux: assert property (p_aux) else $error("short aux load wrong");
  property p_rep; takeAux && instr.inRepeat |=> refused && !auxWe; endproperty
  a_rep: assert property (p_rep) else $error("repeat not refused");
  property p_skip; postModSkip |-> auxWe; endproperty
  a_skip: assert property (p_skip) else $error("skip without aux write");
  property p_req; memReq |-> busy ##1 !memReq; endproperty
  a_req: assert property (p_req) else $error("memory request malformed");
  property p_acc; !$stable(acc) |-> $past(instr.valid) || $past(memRd.valid); endproperty
  a_acc: assert property (p_acc) else $error("acc changed without cause");
endmodule : alx_load_exec_props

bind alx_load_exec alx_load_exec_props u_props (.clk, .rst_n, .instr, .memRd, .statusPtrWe, .statusPtr, .busy,
  .memReq, .acc, .aux_pointer, .aux_pointer_buffer, .auxWe, .auxSel, .auxData, .postModSkip, .refused);

// [test/alx_load_exec_tb_top.sv]
`timescale 1ns/1ps
module alx_load_exec_tb_top
  import alx_pkg::*;
;
  logic clk = 0, rst_n = 0, sign_ext_mode = 0, statusPtrWe = 0, statusBufWe = 0;
  logic busy, memReq, auxWe, postModSkip, refused;
  logic [2:0] statusPtr = 0, statusBuf = 0, aux_pointer, aux_pointer_buffer, auxSel;
  logic [15:0] tempReg = 0, auxData, op;
  logic [31:0] acc;
  logic [8:0] page_pointer;
  logic [3:0] sh;
  alx_instr_t instr = '0;
  alx_mem_t memRd = '0;
  int bad_count = 0, total_checks = 0, cycles = 0;
  alx_load_exec dut (.clk, .rst_n, .instr, .memRd, .sign_ext_mode, .tempReg, .statusPtrWe, .statusPtr, .statusBufWe,
    .statusBuf, .busy, .memReq, .acc, .aux_pointer, .aux_pointer_buffer, .page_pointer, .auxWe, .auxSel, .auxData,
    .postModSkip, .refused);
  always #20 clk = ~clk;
  // ==========
  // access tasks
  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin bad_count++; $display("unexpected at %0t got %h exp %h", $time, g, e); end
  endtask : chk
  task issue(input logic [15:0] w, input logic rp, input logic two, input logic [15:0] opw);
    int n;
    n = 0;
    do begin @(posedge clk); #1; end while (busy !== 1'b0 && ++n < 20);
    instr = '{1'b1, w, rp};
    @(posedge clk); #1;
    if (two) begin instr.word = opw; @(posedge clk); #1; end
    instr.valid = 1'b0;
  endtask : issue
  task mem(input logic [15:0] w, input logic [15:0] d);
    issue(w, 0, 0, 0);
    chk(memReq, 1);
    chk(busy, 1);
    memRd = '{1'b1, d};
    @(posedge clk); #1;
    memRd.valid = 1'b0;
  endtask : mem
  always @(posedge clk) begin cycles++; if (cycles == 1000) begin bad_count++; give_verdict(); end end
  // ==========
  // scenarios
  initial
  begin
    repeat (4) @(posedge clk);
    #1 rst_n = 1;
    sign_ext_mode = 1;
    issue(16'hCAF5, 0, 0, 0); chk(acc, 32'h0000_00F5);
    for (int i = 0; i < 8; i++)
    begin
      sign_ext_mode = i[1]; sh = i[0] ? 4'hF : 4'h0; op = i[2] ? 16'h0794 : 16'hF794;
      issue({4'hD, sh, 8'h01}, 0, 1, op);
      chk(acc, {{16{sign_ext_mode & op[15]}}, op} << sh);
      chk(acc[31], sign_ext_mode & op[15]);
    end
    sign_ext_mode = 1; tempReg = 16'h00F3;
    mem(16'h4280, 16'h8001); chk(acc, 32'hFFFC_0008);
    statusPtrWe = 1; statusPtr = 3; statusBufWe = 1; statusBuf = 6;
    @(posedge clk); #1 statusPtrWe = 0; statusBufWe = 0;
    chk({aux_pointer, aux_pointer_buffer}, {3'h3, 3'h6});
    issue(16'h558D, 0, 0, 0); chk({aux_pointer, aux_pointer_buffer}, {3'h5, 3'h3});
    issue(16'h558A, 0, 0, 0); chk({aux_pointer, aux_pointer_buffer}, {3'h2, 3'h5});
    mem(16'h3280, 16'hBEEF); chk({auxWe, postModSkip, auxSel, auxData}, {2'b11, 3'h2, 16'hBEEF});
    mem(16'h328B, 16'h5A5A);
    chk({auxWe, postModSkip, auxSel, auxData, aux_pointer}, {2'b11, 3'h2, 16'h5A5A, 3'h3});
    mem(16'h3705, 16'h1234); chk({auxWe, postModSkip, auxSel, auxData}, {2'b10, 3'h7, 16'h1234});
    issue(16'hC6A5, 0, 0, 0); chk({auxWe, auxSel, auxData}, {1'b1, 3'h6, 16'h00A5});
    issue(16'hC35A, 1, 0, 0); chk({refused, auxWe}, 2'b10);
    mem(16'h5200, 16'hFFDC); chk(page_pointer, 9'h1DC);
    give_verdict();
  end
endmodule : alx_load_exec_tb_top
